// *** design/gda_pkg.sv ***
// Constants for the decade autoranger: range codes, comparator thresholds, step states, step timing.
// Assumes a single 125 MHz clock and an active-low asynchronous reset.
package gda_pkg;
   // ==========================================================
   // Clock and stepping tick
   localparam int unsigned CLOCK_HZ = 125000000;
   localparam int unsigned STEP_PERIOD_MS = 350;
   localparam int unsigned STEP_CYCLES = CLOCK_HZ / 1000 * STEP_PERIOD_MS;
   localparam int unsigned TICK_W = 26;

   // ==========================================================
   // Decade codes, 10^-8 lowest pressure to 10^-4 highest
   localparam logic [2:0] DEC_E8 = 3'h0;
   localparam logic [2:0] DEC_E7 = 3'h1;
   localparam logic [2:0] DEC_E6 = 3'h2;
   localparam logic [2:0] DEC_E5 = 3'h3;
   localparam logic [2:0] DEC_E4 = 3'h4;
   localparam logic [2:0] DEC_RESET = DEC_E8;

   // ==========================================================
   // Thresholds in tenths of a percent of display full scale (reading 10.0)
   localparam logic [10:0] UPPER_PERMILLE = 11'h492;
   localparam logic [10:0] LOWER_PERMILLE = 11'h05f;
   localparam logic [7:0] FULL_SCALE_TENTHS = 8'h64;

   // ==========================================================
   // Step decision states
   typedef enum logic [2:0] {
      GDA_HOLD = 3'b001,
      GDA_UP = 3'b010,
      GDA_DOWN = 3'b100
   } gda_step_t;
endpackage

// *** design/gda_sync.sv ***
// Two-flop synchroniser for one level input.
// Assumes the input is a slow level relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module gda_sync (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

// *** design/gda_autoranger.sv ***
// Decade autoranger: comparator levels and manual requests step a saturating counter.
// Assumes comparators and manual switch arrive as levels; electrometer is outside.
//
// How it works
// - Auto stepping only while filament on and autorange enabled both hold.
// - Level above 117 percent of full scale steps to higher pressure decade.
// - Level below 9.5 percent of full scale steps to lower pressure decade.
// - Thresholds are relative to a displayed full scale of 10.0.
// - At most one decade per tick; tick period about 0.35 s.
// - Counter saturates between 10^-8 and 10^-4 decades.
// - Power-up reset forces the counter to its initial decade.
// - Counter value decodes to one-hot feedback switch and converter selects.
// - Autorange off: manual up or down requests step one decade each.
// - Pressure output flagged valid only with filament and autorange on.
`timescale 1ns/1ps
`default_nettype none
// The bench may shorten the tick; hardware keeps the package value
module gda_autoranger #(
   parameter int unsigned STEP_CYCLES = gda_pkg::STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic filament_on,
   input wire logic autorange_en,
   input wire logic upper_threshold_comparator,
   input wire logic lower_threshold_comparator,
   input wire logic manual_range_up,
   input wire logic manual_range_down,
   output logic [2:0] decade,
   output logic [4:0] feedback_select,
   output logic [4:0] converter_select,
   output logic range_limit_stop,
   output logic pressure_valid,
   output logic step_tick
);
   // ==========================================================
   // Input synchronisers
   logic upper_s;
   logic lower_s;
   logic man_up_s;
   logic man_dn_s;
   logic fil_s;
   logic auto_s;

   gda_sync u_sync_up (.clock(clock), .rst_b(rst_b), .d(upper_threshold_comparator), .q(upper_s));
   gda_sync u_sync_lo (.clock(clock), .rst_b(rst_b), .d(lower_threshold_comparator), .q(lower_s));
   gda_sync u_sync_mu (.clock(clock), .rst_b(rst_b), .d(manual_range_up), .q(man_up_s));
   gda_sync u_sync_md (.clock(clock), .rst_b(rst_b), .d(manual_range_down), .q(man_dn_s));
   gda_sync u_sync_fl (.clock(clock), .rst_b(rst_b), .d(filament_on), .q(fil_s));
   gda_sync u_sync_au (.clock(clock), .rst_b(rst_b), .d(autorange_en), .q(auto_s));

   // ==========================================================
   // Stepping clock divider
   logic [25:0] tick_cnt;
   logic [25:0] next_tick_cnt;
   logic tick;
   logic next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + 26'h1;
      if (tick_cnt == 26'(STEP_CYCLES - 1)) begin
         next_tick_cnt = 26'h0;
         next_tick = 1'b1;
      end
   end

   // Counter restarts at reset so the first tick comes one period after release
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt <= 26'h0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   // ==========================================================
   // Manual request capture: one edge, one pending step
   logic man_up_d;
   logic man_dn_d;
   logic next_man_up_d;
   logic next_man_dn_d;
   logic pend_up;
   logic pend_dn;
   logic next_pend_up;
   logic next_pend_dn;
   logic auto_run;
   gda_pkg::gda_step_t step;

   assign auto_run = fil_s & auto_s;

   always_comb begin
      next_man_up_d = man_up_s;
      next_man_dn_d = man_dn_s;
      next_pend_up = pend_up;
      next_pend_dn = pend_dn;
      if (tick) begin
         next_pend_up = 1'b0;
         next_pend_dn = 1'b0;
      end
      // A new edge wins over the tick clear so no request is lost
      if (!auto_run && man_up_s && !man_up_d) begin
         next_pend_up = 1'b1;
         next_pend_dn = 1'b0;
      end
      if (!auto_run && man_dn_s && !man_dn_d) begin
         next_pend_dn = 1'b1;
         next_pend_up = 1'b0;
      end
      if (auto_run) begin
         next_pend_up = 1'b0;
         next_pend_dn = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         man_up_d <= 1'b0;
         man_dn_d <= 1'b0;
         pend_up <= 1'b0;
         pend_dn <= 1'b0;
      end else begin
         man_up_d <= next_man_up_d;
         man_dn_d <= next_man_dn_d;
         pend_up <= next_pend_up;
         pend_dn <= next_pend_dn;
      end
   end

   // ==========================================================
   // Step decision: comparators already encode the 117 and 9.5 percent points
   always_comb begin
      step = gda_pkg::GDA_HOLD;
      // Upper is tried first; one level can never trip both comparators
      if (auto_run) begin
         if (upper_s) begin
            step = gda_pkg::GDA_UP;
         end else if (lower_s) begin
            step = gda_pkg::GDA_DOWN;
         end
      end else if (pend_up) begin
         step = gda_pkg::GDA_UP;
      end else if (pend_dn) begin
         step = gda_pkg::GDA_DOWN;
      end
   end

   // ==========================================================
   // Saturating decade counter
   logic [2:0] next_decade;
   logic next_stop;

   always_comb begin
      next_decade = decade;
      next_stop = (decade == gda_pkg::DEC_E4) || (decade == gda_pkg::DEC_E8);
      // Codes above the top decade cannot arise; this only recovers from an upset
      if (decade > gda_pkg::DEC_E4) begin
         next_decade = gda_pkg::DEC_RESET;
      end else if (tick) begin
         unique case (step)
            gda_pkg::GDA_UP: begin
               if (decade != gda_pkg::DEC_E4) begin
                  next_decade = decade + 3'h1;
               end
            end
            gda_pkg::GDA_DOWN: begin
               if (decade != gda_pkg::DEC_E8) begin
                  next_decade = decade - 3'h1;
               end
            end
            gda_pkg::GDA_HOLD: begin
               next_decade = decade;
            end
         endcase
      end
      next_stop = (next_decade == gda_pkg::DEC_E4) || (next_decade == gda_pkg::DEC_E8);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         decade <= gda_pkg::DEC_RESET;
         range_limit_stop <= 1'b1;
      end else begin
         decade <= next_decade;
         range_limit_stop <= next_stop;
      end
   end

   // ==========================================================
   // Decoder; registered so outputs never glitch on a step
   logic [4:0] next_sel;
   logic next_valid;
   logic next_step_tick;

   always_comb begin
      next_sel = 5'h01 << next_decade;
      if (next_decade > gda_pkg::DEC_E4) begin
         next_sel = 5'h01;
      end
      next_valid = auto_run;
      // Delayed one cycle so the pulse marks the cycle that shows the new decade
      next_step_tick = tick;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         feedback_select <= 5'h01;
         converter_select <= 5'h01;
         pressure_valid <= 1'b0;
         step_tick <= 1'b0;
      end else begin
         feedback_select <= next_sel;
         converter_select <= next_sel;
         pressure_valid <= next_valid;
         step_tick <= next_step_tick;
      end
   end
endmodule
`default_nettype wire

// *** verif/gda_props.sv ***
// Port checker for the decade autoranger.
// Assumes one clock domain and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module gda_props (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic filament_on,
   input wire logic autorange_en,
   input wire logic [2:0] decade,
   input wire logic [4:0] feedback_select,
   input wire logic [4:0] converter_select,
   input wire logic range_limit_stop,
   input wire logic pressure_valid,
   input wire logic step_tick
);
   // =====
   // Checks
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_on;
      filament_on && autorange_en;
   endsequence
   sequence s_hold;
      $stable(decade) [*2];
   endsequence
   // Five cycles cover the synchroniser and output register
   property p_von;
      s_on [*5] |-> pressure_valid;
   endproperty
   a_von: assert property (p_von) else $error("valid stays low");
   property p_voff;
      !(filament_on && autorange_en) [*5] |-> !pressure_valid;
   endproperty
   a_voff: assert property (p_voff) else $error("valid while off");
   property p_move;
      $changed(decade) |-> step_tick;
   endproperty
   a_move: assert property (p_move) else $error("step off tick");
   property p_one;
      step_tick |-> (decade - $past(decade)) inside {3'h0, 3'h1, 3'h7};
   endproperty
   a_one: assert property (p_one) else $error("step over one");
   property p_pulse;
      step_tick |=> !step_tick;
   endproperty
   a_pulse: assert property (p_pulse) else $error("tick too long");
   property p_range;
      decade <= 3'h4;
   endproperty
   a_range: assert property (p_range) else $error("bad decade");
   property p_fb;
      s_hold |-> feedback_select == (5'h01 << decade);
   endproperty
   a_fb: assert property (p_fb) else $error("bad decode");
   property p_conv;
      s_hold |-> converter_select == feedback_select;
   endproperty
   a_conv: assert property (p_conv) else $error("bad converter");
   property p_stop;
      s_hold |-> range_limit_stop == (decade == 3'h0 || decade == 3'h4);
   endproperty
   a_stop: assert property (p_stop) else $error("bad limit");
endmodule
bind gda_autoranger gda_props u_props (.clock, .rst_b, .filament_on, .autorange_en, .decade,
   .feedback_select, .converter_select, .range_limit_stop, .pressure_valid, .step_tick);
`default_nettype wire

// *** verif/gda_meter.sv ***
// Electrometer stand-in: level to threshold comparators.
// Assumes level in tenths of a percent of full scale.
`timescale 1ns/1ps
`default_nettype none
module gda_meter (
   input wire logic [10:0] level,
   output logic upper,
   output logic lower
);
   // =====
   // Full scale is a reading of 10.0
   assign upper = level > gda_pkg::UPPER_PERMILLE;
   assign lower = level < gda_pkg::LOWER_PERMILLE;
endmodule
`default_nettype wire

// *** verif/gda_autoranger_tb_top.sv ***
// Bench for the autoranger with a meter stand-in and a decade model.
// Assumes the tick is shortened by parameter so every period ends in a step decision.
`timescale 1ns/1ps
`default_nettype none
module gda_autoranger_tb_top;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic filament_on, autorange_en, manual_up, manual_down, upper, lower;
   logic [10:0] level;
   logic [2:0] decade;
   logic [4:0] feedback_select, converter_select;
   logic range_limit_stop, pressure_valid, step_tick;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 32'hbe9e87ca;
   int exp_q[$];
   int exp_dec = 0;
   int dir = 0;
   // A short tick keeps the run small; the divider logic is the same
   localparam int unsigned TB_STEP = 16;
   localparam int PERIODS = 200;
   always #4 clock = ~clock;
   gda_meter u_meter (.level, .upper, .lower);
   gda_autoranger #(.STEP_CYCLES(TB_STEP)) u_dut (.clock, .rst_b, .filament_on, .autorange_en,
      .upper_threshold_comparator(upper), .lower_threshold_comparator(lower), .manual_range_up(manual_up),
      .manual_range_down(manual_down), .decade, .feedback_select, .converter_select, .range_limit_stop,
      .pressure_valid, .step_tick);
   // =====
   // Compare and close
   task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_reset;
      cmp({4'h0, pressure_valid}, 5'h00);
      cmp({2'h0, decade}, {2'h0, gda_pkg::DEC_RESET});
      cmp(feedback_select, 5'(1 << gda_pkg::DEC_RESET));
      cmp(converter_select, 5'(1 << gda_pkg::DEC_RESET));
      cmp({4'h0, range_limit_stop}, 5'h01);
      cmp({4'h0, step_tick}, 5'h00);
   endtask
   task automatic check_range(input int want, input logic want_tick, input logic want_valid);
      cmp({2'h0, decade}, 5'(want));
      cmp(feedback_select, 5'(1 << want));
      cmp(converter_select, 5'(1 << want));
      cmp({4'h0, range_limit_stop}, {4'h0, (want == int'(gda_pkg::DEC_E8)) || (want == int'(gda_pkg::DEC_E4))});
      cmp({4'h0, step_tick}, {4'h0, want_tick});
      cmp({4'h0, pressure_valid}, {4'h0, want_valid});
   endtask
   // Model of one tick: auto uses the level, manual uses the request, both saturate
   function automatic int model_step(input int cur, input logic auto_on, input int lvl, input int man);
      int nxt;
      nxt = cur;
      if (auto_on) begin
         if (lvl > int'(gda_pkg::UPPER_PERMILLE)) begin
            nxt = cur + 1;
         end else if (lvl < int'(gda_pkg::LOWER_PERMILLE)) begin
            nxt = cur - 1;
         end
      end else begin
         nxt = cur + man;
      end
      if (nxt > int'(gda_pkg::DEC_E4)) begin
         nxt = int'(gda_pkg::DEC_E4);
      end
      if (nxt < int'(gda_pkg::DEC_E8)) begin
         nxt = int'(gda_pkg::DEC_E8);
      end
      return nxt;
   endfunction
   task automatic wrap_up;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // =====
   // Stimulus: one tick period per pass, inputs set just after a step, one mid-run reset
   initial begin
      {filament_on, autorange_en, manual_up, manual_down, level} = 15'h0000;
      repeat (5) @(negedge clock);
      check_reset();
      rst_b = 1'b1;
      @(negedge clock);
      check_reset();
      for (int i = 0; i < PERIODS; i++) begin
         if (i == PERIODS / 2) begin
            rst_b = 1'b0;
            @(negedge clock);
            check_reset();
            rst_b = 1'b1;
            exp_dec = int'(gda_pkg::DEC_RESET);
            @(negedge clock);
            check_reset();
         end
         {filament_on, autorange_en, level} = 13'($random(seed));
         {manual_up, manual_down} = 2'h0;
         dir = int'($unsigned($random(seed)) % 3) - 1;
         if (i < 6) begin
            // Walk to the top decade and push against it
            {filament_on, autorange_en} = 2'h0;
            dir = 1;
         end
         exp_q.push_back(model_step(exp_dec, filament_on & autorange_en, int'(level), dir));
         repeat (3) @(negedge clock);
         // At most one line rises per period, so one toggle asks one direction
         manual_up = (dir > 0);
         manual_down = (dir < 0);
         repeat (4) @(negedge clock);
         check_range(exp_dec, 1'b0, filament_on & autorange_en);
         repeat (TB_STEP - 7) @(negedge clock);
         exp_dec = exp_q.pop_front();
         check_range(exp_dec, 1'b1, filament_on & autorange_en);
      end
      wrap_up();
   end
   // Hang guard: three times the planned run, reckoned in clock cycles
   initial begin
      repeat (3 * PERIODS * (TB_STEP + 2)) @(posedge clock);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
